// File: hdl/pwm_consts.vh
`ifndef PWM_CONSTS_VH
`define PWM_CONSTS_VH
// Register byte addresses on the APB.
`define ADDR_TIME_BASE_CTRL 12'h000
`define ADDR_PRIMARY_PERIOD 12'h004
`define ADDR_SECONDARY_PERIOD 12'h008
`define ADDR_GEN_CTRL 12'h00c
`define ADDR_PIN_CTRL 12'h010
`define ADDR_DUTY 12'h014
`define ADDR_PHASE 12'h018
`define ADDR_DEAD_TIME 12'h01c
`define ADDR_STATUS 12'h020
// Time base control register fields.
`define BIT_MODULE_ENABLE 15
// Generator control register fields.
`define BIT_MASTER_SELECT 3
`define BIT_EXT_RESET_EN 1
`define BIT_INDEPENDENT 2
`define BIT_FAULT_EN 4
`define BIT_CLIMIT_EN 5
// Pin control register fields.
`define BIT_HIGH_OWN 15
`define BIT_LOW_OWN 14
`define BIT_HIGH_OVR_EN 9
`define BIT_LOW_OVR_EN 8
`define BIT_OVR_DATA_HI 7
`define BIT_OVR_DATA_LO 6
`define BIT_FAULT_DATA_HI 5
`define BIT_FAULT_DATA_LO 4
`define BIT_CLIMIT_DATA_HI 3
`define BIT_CLIMIT_DATA_LO 2
`define BIT_SWAP 1
// Reset values.
`define RESET_PERIOD 16'h0064
`define RESET_PIN_CTRL 16'h0000
`endif

// File: hdl/pwm_time_base.v
`default_nettype none
`include "pwm_consts.vh"
// One counter with its compare; the counter wraps at the period and can be
// restarted from outside.
module pwm_time_base #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire clk_in,
    input wire reset_in,
    // Control
    input wire run_in,
    input wire restart_in,
    input wire [WIDTH-1:0] period_in,
    input wire [WIDTH-1:0] phase_in,
    input wire [WIDTH-1:0] duty_in,
    // Results
    output reg wave_out,
    output wire boundary_out
);
    reg [WIDTH-1:0] count_reg;

    assign boundary_out = run_in && (count_reg >= period_in);

    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            count_reg <= {WIDTH{1'b0}};
            wave_out <= 1'b0;
        end else if (!run_in) begin
            count_reg <= phase_in;
            wave_out <= 1'b0;
        end else begin
            if (restart_in || boundary_out) begin
                count_reg <= phase_in;
            end else begin
                count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
            end
            wave_out <= (count_reg < duty_in);
        end
    end
endmodule // pwm_time_base
`default_nettype wire

// File: hdl/pwm_output_and_update_control.v
`default_nettype none
`include "pwm_consts.vh"
module pwm_output_and_update_control #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire clk_in,
    input wire reset_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    // External conditions from pins
    input wire fault_in,
    input wire current_limit_in,
    input wire ext_period_reset_in,
    // GPIO values for pins not owned by the generator
    input wire gpio_high_in,
    input wire gpio_low_in,
    // Pins
    output reg high_side_output_out,
    output reg low_side_output_out,
    output reg high_side_oe_out,
    output reg low_side_oe_out
);
    reg [15:0] time_base_control_register_reg;
    reg [15:0] primary_master_period_reg;
    reg [15:0] secondary_master_period_reg;
    reg [15:0] generator_control_register_reg;
    reg [15:0] pin_control_register_reg;
    reg [WIDTH-1:0] duty_reg;
    reg [WIDTH-1:0] phase_reg;
    reg [WIDTH-1:0] dead_time_reg;
    // Active copies that the generator really uses.
    reg [WIDTH-1:0] act_period_reg;
    reg [WIDTH-1:0] act_duty_reg;
    reg [WIDTH-1:0] act_phase_reg;
    reg [WIDTH-1:0] act_dead_reg;
    reg [1:0] fault_sync_reg;
    reg [1:0] climit_sync_reg;
    reg [1:0] xres_sync_reg;
    reg [WIDTH-1:0] dead_count_reg;
    reg high_wave_reg;
    reg low_wave_reg;
    reg prev_wave_reg;

    wire module_enable = time_base_control_register_reg[`BIT_MODULE_ENABLE];
    wire [15:0] pin_ctrl = pin_control_register_reg;
    wire [15:0] gen_ctrl = generator_control_register_reg;
    wire [WIDTH-1:0] master_period = gen_ctrl[`BIT_MASTER_SELECT] ?
        secondary_master_period_reg[WIDTH-1:0] :
        primary_master_period_reg[WIDTH-1:0];
    wire ext_reset = xres_sync_reg[1] && gen_ctrl[`BIT_EXT_RESET_EN];
    wire fault_active = fault_sync_reg[1] && gen_ctrl[`BIT_FAULT_EN];
    wire climit_active = climit_sync_reg[1] && gen_ctrl[`BIT_CLIMIT_EN];
    wire raw_wave;
    wire boundary;
    wire apb_write = psel_in && penable_in && pwrite_in;

    pwm_time_base #(
        .WIDTH(WIDTH)
    ) time_base (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .run_in(module_enable),
        .restart_in(ext_reset),
        .period_in(act_period_reg),
        .phase_in(act_phase_reg),
        .duty_in(act_duty_reg),
        .wave_out(raw_wave),
        .boundary_out(boundary)
    );

    assign pready_out = 1'b1;
    assign pslverr_out = 1'b0;

    function [15:0] merge;
        input [15:0] old_value;
        input [31:0] wdata;
        begin
            merge = wdata[15:0] | (old_value & 16'h0000);
        end
    endfunction

    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            time_base_control_register_reg <= 16'h0000;
            primary_master_period_reg <= `RESET_PERIOD;
            secondary_master_period_reg <= `RESET_PERIOD;
            generator_control_register_reg <= 16'h0000;
            pin_control_register_reg <= `RESET_PIN_CTRL;
            duty_reg <= {WIDTH{1'b0}};
            phase_reg <= {WIDTH{1'b0}};
            dead_time_reg <= {WIDTH{1'b0}};
        end else if (apb_write) begin
            case (paddr_in)
                `ADDR_TIME_BASE_CTRL: time_base_control_register_reg <= merge(16'h0000, pwdata_in);
                `ADDR_PRIMARY_PERIOD: primary_master_period_reg <= merge(16'h0000, pwdata_in);
                `ADDR_SECONDARY_PERIOD: secondary_master_period_reg <= merge(16'h0000, pwdata_in);
                `ADDR_GEN_CTRL: generator_control_register_reg <= merge(16'h0000, pwdata_in);
                `ADDR_PIN_CTRL: pin_control_register_reg <= merge(16'h0000, pwdata_in);
                `ADDR_DUTY: duty_reg <= pwdata_in[WIDTH-1:0];
                `ADDR_PHASE: phase_reg <= pwdata_in[WIDTH-1:0];
                `ADDR_DEAD_TIME: dead_time_reg <= pwdata_in[WIDTH-1:0];
                default: ;
            endcase
        end
    end

    always @* begin
        case (paddr_in)
            `ADDR_TIME_BASE_CTRL: prdata_out = {16'h0000, time_base_control_register_reg};
            `ADDR_PRIMARY_PERIOD: prdata_out = {16'h0000, primary_master_period_reg};
            `ADDR_SECONDARY_PERIOD: prdata_out = {16'h0000, secondary_master_period_reg};
            `ADDR_GEN_CTRL: prdata_out = {16'h0000, generator_control_register_reg};
            `ADDR_PIN_CTRL: prdata_out = {16'h0000, pin_control_register_reg};
            `ADDR_DUTY: prdata_out = {{(32-WIDTH){1'b0}}, duty_reg};
            `ADDR_PHASE: prdata_out = {{(32-WIDTH){1'b0}}, phase_reg};
            `ADDR_DEAD_TIME: prdata_out = {{(32-WIDTH){1'b0}}, dead_time_reg};
            `ADDR_STATUS: prdata_out = {27'h0000000, high_wave_reg, low_wave_reg,
                climit_active, fault_active, module_enable};
            default: prdata_out = 32'h00000000;
        endcase
    end

    // All shadows load on the same boundary so nothing lags a cycle behind.
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            act_period_reg <= `RESET_PERIOD;
            act_duty_reg <= {WIDTH{1'b0}};
            act_phase_reg <= {WIDTH{1'b0}};
            act_dead_reg <= {WIDTH{1'b0}};
        end else if (!module_enable || boundary) begin
            act_period_reg <= master_period;
            act_duty_reg <= duty_reg;
            act_phase_reg <= phase_reg;
            act_dead_reg <= dead_time_reg;
        end
    end

    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            fault_sync_reg <= 2'h0;
            climit_sync_reg <= 2'h0;
            xres_sync_reg <= 2'h0;
        end else begin
            fault_sync_reg <= {fault_sync_reg[0], fault_in};
            climit_sync_reg <= {climit_sync_reg[0], current_limit_in};
            xres_sync_reg <= {xres_sync_reg[0], ext_period_reset_in};
        end
    end

    // Dead time delays each rising edge in complementary mode; independent
    // mode drives the low side as a separate copy from the same restarted base.
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            dead_count_reg <= {WIDTH{1'b0}};
            prev_wave_reg <= 1'b0;
            high_wave_reg <= 1'b0;
            low_wave_reg <= 1'b0;
        end else if (!module_enable) begin
            dead_count_reg <= {WIDTH{1'b0}};
            prev_wave_reg <= 1'b0;
            high_wave_reg <= 1'b0;
            low_wave_reg <= 1'b0;
        end else begin
            prev_wave_reg <= raw_wave;
            if (raw_wave != prev_wave_reg) begin
                dead_count_reg <= act_dead_reg;
            end else if (dead_count_reg != {WIDTH{1'b0}}) begin
                dead_count_reg <= dead_count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
            end
            if (gen_ctrl[`BIT_INDEPENDENT]) begin
                high_wave_reg <= raw_wave;
                low_wave_reg <= raw_wave;
            end else begin
                high_wave_reg <= raw_wave && (raw_wave == prev_wave_reg) &&
                    (dead_count_reg == {WIDTH{1'b0}});
                low_wave_reg <= !raw_wave && (raw_wave == prev_wave_reg) &&
                    (dead_count_reg == {WIDTH{1'b0}});
            end
        end
    end

    // Output stage: swap, then override, then fault/limit, then ownership.
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            high_side_output_out <= 1'b0;
            low_side_output_out <= 1'b0;
            high_side_oe_out <= 1'b0;
            low_side_oe_out <= 1'b0;
        end else begin
            high_side_oe_out <= 1'b1;
            low_side_oe_out <= 1'b1;
            if (!pin_ctrl[`BIT_HIGH_OWN]) begin
                high_side_output_out <= gpio_high_in;
            end else if (fault_active) begin
                high_side_output_out <= pin_ctrl[`BIT_FAULT_DATA_HI];
            end else if (climit_active) begin
                high_side_output_out <= pin_ctrl[`BIT_CLIMIT_DATA_HI];
            end else if (pin_ctrl[`BIT_HIGH_OVR_EN]) begin
                high_side_output_out <= pin_ctrl[`BIT_OVR_DATA_HI];
            end else begin
                high_side_output_out <= pin_ctrl[`BIT_SWAP] ? low_wave_reg : high_wave_reg;
            end
            if (!pin_ctrl[`BIT_LOW_OWN]) begin
                low_side_output_out <= gpio_low_in;
            end else if (fault_active) begin
                low_side_output_out <= pin_ctrl[`BIT_FAULT_DATA_LO];
            end else if (climit_active) begin
                low_side_output_out <= pin_ctrl[`BIT_CLIMIT_DATA_LO];
            end else if (pin_ctrl[`BIT_LOW_OVR_EN]) begin
                low_side_output_out <= pin_ctrl[`BIT_OVR_DATA_LO];
            end else begin
                low_side_output_out <= pin_ctrl[`BIT_SWAP] ? high_wave_reg : low_wave_reg;
            end
        end
    end
endmodule // pwm_output_and_update_control
`default_nettype wire

// File: sim/pwm_checks_properties.sv
`default_nettype none
`include "pwm_consts.vh"
module pwm_checks (
    // Clock, reset and bus
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic pready_out,
    // Pin side
    input wire logic fault_in,
    input wire logic current_limit_in,
    input wire logic gpio_high_in,
    input wire logic gpio_low_in,
    input wire logic high_side_output_out,
    input wire logic low_side_output_out,
    input wire logic high_side_oe_out,
    input wire logic low_side_oe_out
);
    logic [15:0] pin_reg;
    logic [15:0] gen_reg;
    // Shadow copies of the control words, since only the ports are visible here.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_reg <= `RESET_PIN_CTRL;
            gen_reg <= 16'h0000;
        end else if (psel_in && penable_in && pwrite_in) begin
            if (paddr_in == `ADDR_PIN_CTRL)
                pin_reg <= pwdata_in[15:0];
            if (paddr_in == `ADDR_GEN_CTRL)
                gen_reg <= pwdata_in[15:0];
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    a_zero_wait: assert property (psel_in && penable_in |-> pready_out)
        else $error("access phase stalled");
    a_oe_driven: assert property (!$past(reset_in) |-> high_side_oe_out && low_side_oe_out)
        else $error("pin not driven after reset");
    a_gpio_high: assert property (
        (!pin_reg[15] && $stable(gpio_high_in))[*4] |-> high_side_output_out == gpio_high_in)
        else $error("high pin not following gpio");
    a_gpio_low: assert property (
        (!pin_reg[14] && $stable(gpio_low_in))[*4] |-> low_side_output_out == gpio_low_in)
        else $error("low pin not following gpio");
    a_ovr_high: assert property (
        (pin_reg[15] && pin_reg[9] && gen_reg[5:4] == 2'h0 && $stable(pin_reg))[*4]
        |-> high_side_output_out == pin_reg[7]) else $error("high override level wrong");
    a_ovr_low: assert property (
        (pin_reg[14] && pin_reg[8] && gen_reg[5:4] == 2'h0 && $stable(pin_reg))[*4]
        |-> low_side_output_out == pin_reg[6]) else $error("low override level wrong");
    a_fault_high: assert property (
        (pin_reg[15] && gen_reg[4] && fault_in && $stable(pin_reg))[*4]
        |-> high_side_output_out == pin_reg[5]) else $error("high fault level wrong");
    a_limit_low: assert property (
        (pin_reg[14] && gen_reg[5] && !gen_reg[4] && current_limit_in && $stable(pin_reg))[*4]
        |-> low_side_output_out == pin_reg[2]) else $error("low limit level wrong");
endmodule // pwm_checks
`default_nettype wire

// File: sim/pwm_far_side.sv
`default_nettype none
// Gate driver stand-in: sources the condition lines and measures the pins.
module pwm_far_side (
    input wire logic clk_in,
    input wire logic [2:0] cond_req_in,
    input wire logic high_pin_in,
    input wire logic low_pin_in,
    output logic [2:0] cond_out,
    output int period_out,
    output int toggles_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int count = 0;
    logic last_h = 1'b0;
    logic last_l = 1'b0;
    // Each output has one driver, so the start values live on these variables.
    logic [2:0] cond_reg = 3'h0;
    int period_reg = 0;
    int toggles_reg = 0;
    assign cond_out = cond_reg;
    assign period_out = period_reg;
    assign toggles_out = toggles_reg;
    always @(posedge clk_in) begin
        cond_reg <= cond_req_in;
        last_h <= high_pin_in;
        last_l <= low_pin_in;
        count <= count + 1;
        if (high_pin_in && !last_h) begin
            period_reg <= count;
            count <= 1;
        end
        if (high_pin_in != last_h || low_pin_in != last_l)
            toggles_reg <= toggles_reg + 1;
    end
endmodule // pwm_far_side
`default_nettype wire

// File: sim/tb_pwm_output_and_update_control.sv
`default_nettype none
`include "pwm_consts.vh"
module tb_pwm_output_and_update_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, gh = 1'b0, gl = 1'b0;
    logic ho, lo, hoe, loe, prdy, perr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwd = 32'h0, prd;
    logic [2:0] creq = 3'h0, cnd;
    int per, tog, fail_count = 0, checks_done = 0, cycles = 0;
    pwm_output_and_update_control DUT (
        .clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(perr), .fault_in(cnd[0]), .current_limit_in(cnd[1]),
        .ext_period_reset_in(cnd[2]), .gpio_high_in(gh), .gpio_low_in(gl),
        .high_side_output_out(ho), .low_side_output_out(lo), .high_side_oe_out(hoe),
        .low_side_oe_out(loe));
    pwm_far_side far (.clk_in(clk), .cond_req_in(creq), .high_pin_in(ho), .low_pin_in(lo),
        .cond_out(cnd), .period_out(per), .toggles_out(tog));
    initial forever #25 clk = ~clk;
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [15:0] d,
        output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= {16'h0000, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        q = prd;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] q;
        apb(a, 1'b1, d, q);
    endtask
    task automatic t_regs;
        logic [31:0] q;
        apb(`ADDR_PIN_CTRL, 1'b0, 16'h0000, q);
        check(q, {16'h0000, `RESET_PIN_CTRL});
        apb(`ADDR_PRIMARY_PERIOD, 1'b0, 16'h0000, q);
        check(q, {16'h0000, `RESET_PERIOD});
        wr(12'h040, 16'h1234);
        apb(12'h040, 1'b0, 16'h0000, q);
        check(q, 32'h0);
        check(32'(perr), 32'h0);
    endtask
    task automatic t_pins;
        gh <= 1'b1;
        gl <= 1'b1;
        wr(`ADDR_PIN_CTRL, 16'h0000);
        repeat (4) @(posedge clk);
        check(32'({ho, lo}), 32'h3);
        wr(`ADDR_PIN_CTRL, 16'h8200);
        repeat (4) @(posedge clk);
        check(32'({ho, lo}), 32'h1);
        gl <= 1'b0;
        wr(`ADDR_PIN_CTRL, 16'h4140);
        repeat (4) @(posedge clk);
        check(32'({ho, lo}), 32'h3);
    endtask
    task automatic t_enable;
        gh <= 1'b0;
        wr(`ADDR_PRIMARY_PERIOD, 16'h0010);
        wr(`ADDR_DUTY, 16'hffff);
        wr(`ADDR_PIN_CTRL, 16'h0380);
        wr(`ADDR_TIME_BASE_CTRL, 16'h8000);
        wr(`ADDR_PIN_CTRL, 16'h0080);
        repeat (40) @(posedge clk);
        wr(`ADDR_PIN_CTRL, 16'hc000);
        repeat (4) @(posedge clk);
        check(32'({ho, lo}), 32'h2);
        wr(`ADDR_PIN_CTRL, 16'hc002);
        repeat (4) @(posedge clk);
        check(32'({ho, lo}), 32'h1);
    endtask
    task automatic t_period;
        int p1;
        wr(`ADDR_PIN_CTRL, 16'hc000);
        wr(`ADDR_DUTY, 16'h0004);
        wr(`ADDR_PRIMARY_PERIOD, 16'h0014);
        wr(`ADDR_SECONDARY_PERIOD, 16'h0028);
        wr(`ADDR_GEN_CTRL, 16'h0000);
        repeat (100) @(posedge clk);
        p1 = per;
        wr(`ADDR_GEN_CTRL, 16'h0008);
        repeat (150) @(posedge clk);
        check(32'(per - p1), 32'h14);
    endtask
    task automatic t_fault;
        wr(`ADDR_PIN_CTRL, 16'hc020);
        wr(`ADDR_GEN_CTRL, 16'h0010);
        creq <= 3'h1;
        repeat (6) @(posedge clk);
        check(32'({ho, lo}), 32'h2);
        wr(`ADDR_PIN_CTRL, 16'hc022);
        repeat (4) @(posedge clk);
        check(32'({ho, lo}), 32'h2);
        creq <= 3'h2;
        wr(`ADDR_GEN_CTRL, 16'h0020);
        wr(`ADDR_PIN_CTRL, 16'hc00c);
        repeat (6) @(posedge clk);
        check(32'({ho, lo}), 32'h3);
        creq <= 3'h0;
        wr(`ADDR_GEN_CTRL, 16'h0000);
        wr(`ADDR_PIN_CTRL, 16'hc000);
        repeat (100) @(posedge clk);
    endtask
    // Restarts come faster than the duty, so a held time base never lets a pin move.
    task automatic t_hold;
        int t0;
        wr(`ADDR_DUTY, 16'h0014);
        wr(`ADDR_PRIMARY_PERIOD, 16'h0028);
        // Restarts never reach a period boundary, so the new values must load first.
        repeat (45) @(posedge clk);
        wr(`ADDR_GEN_CTRL, 16'h0006);
        for (int k = 0; k < 12; k++) begin
            if (k == 3)
                t0 = tog;
            creq <= 3'h4;
            repeat (2) @(posedge clk);
            creq <= 3'h0;
            repeat (8) @(posedge clk);
        end
        check(32'(tog - t0), 32'h0);
        check(32'(ho), 32'h1);
        check(32'(lo), 32'h1);
        wr(`ADDR_GEN_CTRL, 16'h0000);
        wr(`ADDR_TIME_BASE_CTRL, 16'h0000);
        repeat (10) @(posedge clk);
        t0 = tog;
        repeat (100) @(posedge clk);
        check(32'(tog - t0), 32'h0);
        check(32'({ho, lo}), 32'h0);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        check(32'({ho, lo}), 32'h0);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check(32'({hoe, loe}), 32'h3);
        t_regs();
        t_pins();
        t_enable();
        t_period();
        t_fault();
        t_hold();
        stop_test();
    end
endmodule // tb_pwm_output_and_update_control
bind pwm_output_and_update_control pwm_checks checks (.clk_in(clk_in), .reset_in(reset_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .fault_in(fault_in),
    .current_limit_in(current_limit_in), .gpio_high_in(gpio_high_in),
    .gpio_low_in(gpio_low_in), .high_side_output_out(high_side_output_out),
    .low_side_output_out(low_side_output_out), .high_side_oe_out(high_side_oe_out),
    .low_side_oe_out(low_side_oe_out));
`default_nettype wire
